/* core/ccd_decoder.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// - 16-bit read/write command register; 0x0000 on pin reset, 0xA000 after soft reset.
// - low byte at 0x10, high at 0x11; swapped when bus mode select is high.
// - 0xC200 enables Port B configuration and polarity register access.
// - 0x500X bypass, 0x580X compress; bits 3:2 pad bytes expected on Port A.
// - for compression starts bits 1:0 give pad bytes inserted on Port B.
// - 0x600X, 0x680X, 0x6C0X start the three decompression kinds.
// - decompression starts: bits 3:2 pad bytes expected on Port B.
// - decompression starts: bits 1:0 pad bytes inserted on Port A.
// - pause finishes current step then floats both port data buses.
// - once paused, set paused interrupt and paused status bits.
// - paused transfer keeps its mode and state for later continuation.
// - 0x440X resumes: clears paused bits, sets busy.
// - resume bits 3:2 Port B expected pads, 1:0 Port A inserted pads.
// - 0xA000 resets registers, cancels operation, clears history buffer.
// - soft reset spares port configurations, identification and polarities.
// - 0xA400 clears history only; host issues it between operations.
// - 0x0000 does nothing.
// - Port A FIFO control reachable only while Port A selection is held.
// - bus mode select pin picks bus mode and register byte ordering.
module ccd_decoder (
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  // register port
  input  wire logic              hostBusModeSelect,
  input  wire logic [4:0]        regAddr,
  input  wire logic              regWr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regRd,
  output logic      [7:0]        regRdData,
  // transfer engine
  input  wire logic              stepDone,
  input  wire logic              xferDone,
  output ccd_pkg::ccd_eng_t      eng,
  output logic                   portADataOeN,
  output logic                   portBDataOeN,
  // status and interrupt
  input  wire logic              pausedIntClr,
  output logic                   pausedInt,
  output logic                   pausedStat,
  output logic                   busyStat,
  // register file controls
  output logic                   portACfgEn,
  output logic                   portBCfgEn,
  output logic                   portAFifoCtlEn,
  output logic                   softResetPulse,
  output logic                   swrstInProgress,
  // history buffer engine access
  input  wire logic              histWrEn,
  input  wire logic [ccd_pkg::HIST_AW-1:0] histWrAddr,
  input  wire logic [7:0]        histWrData,
  input  wire logic [ccd_pkg::HIST_AW-1:0] histRdAddr,
  output logic      [7:0]        histRdData,
  output logic                   histClearing
);
  import ccd_pkg::*;

  // ============================================================
  // decode helpers
  function automatic logic [4:0] map_addr(input logic [4:0] a, input logic swap);
    logic [4:0] r;
    r = a;
    if (swap && (a == CMD_ADDR_LO || a == CMD_ADDR_HI)) begin
      r = {a[4:1], ~a[0]};
    end
    return r;
  endfunction

  function automatic ccd_dec_t decode(input logic [15:0] c);
    ccd_dec_t d;
    d = '0;
    d.xfer = XF_NONE;
    if (c == CMD_SEL_A) d.selA = 1'b1;
    if (c == CMD_SEL_B) d.selB = 1'b1;
    if (c == CMD_PAUSE) d.pause = 1'b1;
    if (c == CMD_SWRESET) d.swReset = 1'b1;
    if (c == CMD_HISTRESET) d.histReset = 1'b1;
    if (c[15:4] == CMD_RESUME_HI) d.resume = 1'b1;
    case (c[15:4])
      CMD_CBYP_HI: d.xfer = XF_CBYP;
      CMD_COMP_HI: d.xfer = XF_COMP;
      CMD_DBYP_HI: d.xfer = XF_DBYP;
      CMD_DECO_HI: d.xfer = XF_DECO;
      CMD_DOFF_HI: d.xfer = XF_DOFF;
      default:     d.xfer = XF_NONE;
    endcase
    d.start = (d.xfer != XF_NONE);
    return d;
  endfunction

  function automatic logic is_comp(input ccd_xfer_t x);
    return (x == XF_CBYP) || (x == XF_COMP);
  endfunction

  // ============================================================
  // state
  typedef struct packed {
    ccd_state_t             st;
    logic [15:0]            cmd;
    logic [3:0]             rstCnt;
    logic                   histClr;
    logic [HIST_AW-1:0]     histPtr;
    ccd_eng_t               eng;
    logic                   aOeN;
    logic                   bOeN;
    logic                   pInt;
    logic                   pStat;
    logic                   busy;
    logic                   aCfg;
    logic                   bCfg;
    logic                   aFifo;
    logic                   swPulse;
    logic                   swBusy;
    logic [7:0]             rd;
  } ccd_state_all_t;

  ccd_state_all_t s_r, s_nxt;

  logic [4:0]   mAddr;
  logic [15:0]  newCmd;
  logic         cmdWrite;
  ccd_dec_t     dec;

  always_comb begin
    mAddr = map_addr(regAddr, hostBusModeSelect);
    newCmd = s_r.cmd;
    cmdWrite = 1'b0;
    if (regWr && mAddr == CMD_ADDR_LO) begin
      newCmd[7:0] = regWrData;
      cmdWrite = 1'b1;
    end
    if (regWr && mAddr == CMD_ADDR_HI) begin
      newCmd[15:8] = regWrData;
      cmdWrite = 1'b1;
    end
    // command acts once the high byte lands
    dec = decode(newCmd);
    if (!(regWr && mAddr == CMD_ADDR_HI)) begin
      dec = '0;
      dec.xfer = XF_NONE;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.eng.startPulse = 1'b0;
    s_nxt.eng.cancelPulse = 1'b0;
    s_nxt.swPulse = 1'b0;
    if (cmdWrite && s_r.st != ST_SWRST) begin
      s_nxt.cmd = newCmd;
    end
    // selection flags follow the held command
    s_nxt.aCfg = (s_nxt.cmd == CMD_SEL_A);
    s_nxt.bCfg = (s_nxt.cmd == CMD_SEL_B);
    s_nxt.aFifo = (s_nxt.cmd == CMD_SEL_A);
    // history clear walk
    if (s_r.histClr) begin
      s_nxt.histPtr = s_r.histPtr + 1'b1;
      if (s_r.histPtr == HIST_LAST) s_nxt.histClr = 1'b0;
    end
    if (pausedIntClr && !(s_r.st == ST_PAUSING && stepDone)) begin
      s_nxt.pInt = 1'b0;
    end
    case (s_r.st)
      ST_IDLE, ST_BUSY: begin
        if (s_r.st == ST_BUSY && xferDone) begin
          s_nxt.st = ST_IDLE;
          s_nxt.busy = 1'b0;
          s_nxt.eng.run = 1'b0;
        end
        if (dec.start) begin
          s_nxt.st = ST_BUSY;
          s_nxt.busy = 1'b1;
          s_nxt.eng.mode = dec.xfer;
          s_nxt.eng.run = 1'b1;
          s_nxt.eng.startPulse = 1'b1;
          s_nxt.pInt = 1'b0;
          s_nxt.pStat = 1'b0;
          s_nxt.aOeN = 1'b0;
          s_nxt.bOeN = 1'b0;
          if (is_comp(dec.xfer)) begin
            s_nxt.eng.padExpectA = newCmd[3:2];
            s_nxt.eng.padInsertB = newCmd[1:0];
            s_nxt.eng.padExpectB = 2'b00;
            s_nxt.eng.padInsertA = 2'b00;
          end else begin
            s_nxt.eng.padExpectB = newCmd[3:2];
            s_nxt.eng.padInsertA = newCmd[1:0];
            s_nxt.eng.padExpectA = 2'b00;
            s_nxt.eng.padInsertB = 2'b00;
          end
        end else if (dec.pause && s_r.st == ST_BUSY && !xferDone) begin
          s_nxt.st = ST_PAUSING;
        end
      end
      ST_PAUSING: begin
        if (stepDone) begin
          s_nxt.st = ST_PAUSED;
          s_nxt.eng.run = 1'b0;
          s_nxt.aOeN = 1'b1;
          s_nxt.bOeN = 1'b1;
          s_nxt.pInt = 1'b1;
          s_nxt.pStat = 1'b1;
        end
      end
      ST_PAUSED: begin
        if (dec.resume) begin
          s_nxt.st = ST_BUSY;
          s_nxt.pInt = 1'b0;
          s_nxt.pStat = 1'b0;
          s_nxt.busy = 1'b1;
          s_nxt.eng.run = 1'b1;
          s_nxt.aOeN = 1'b0;
          s_nxt.bOeN = 1'b0;
          s_nxt.eng.padExpectB = newCmd[3:2];
          s_nxt.eng.padInsertA = newCmd[1:0];
        end
      end
      ST_SWRST: begin
        s_nxt.rstCnt = s_r.rstCnt + 1'b1;
        if (s_r.rstCnt == SWRST_LAST) begin
          s_nxt.st = ST_IDLE;
          s_nxt.swBusy = 1'b0;
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (dec.histReset && s_r.st != ST_SWRST) begin
      s_nxt.histClr = 1'b1;
      s_nxt.histPtr = '0;
    end
    if (dec.swReset && s_r.st != ST_SWRST) begin
      // port configuration registers live outside and ignore this
      s_nxt.st = ST_SWRST;
      s_nxt.cmd = CMD_SWRESET;
      s_nxt.rstCnt = '0;
      s_nxt.swBusy = 1'b1;
      s_nxt.swPulse = 1'b1;
      s_nxt.histClr = 1'b1;
      s_nxt.histPtr = '0;
      s_nxt.eng = '0;
      s_nxt.eng.mode = XF_NONE;
      s_nxt.eng.cancelPulse = 1'b1;
      s_nxt.busy = 1'b0;
      s_nxt.pInt = 1'b0;
      s_nxt.pStat = 1'b0;
      s_nxt.aOeN = 1'b1;
      s_nxt.bOeN = 1'b1;
      s_nxt.aCfg = 1'b0;
      s_nxt.bCfg = 1'b0;
      s_nxt.aFifo = 1'b0;
    end
    // read data: command bytes, zero elsewhere
    s_nxt.rd = 8'h00;
    if (regRd && mAddr == CMD_ADDR_LO) s_nxt.rd = s_r.cmd[7:0];
    if (regRd && mAddr == CMD_ADDR_HI) s_nxt.rd = s_r.cmd[15:8];
  end
  // NOP decodes to no action bit at all; relied upon

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.cmd <= CMD_RESET_VAL;
      s_r.eng.mode <= XF_NONE;
      s_r.aOeN <= 1'b1;
      s_r.bOeN <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ============================================================
  // history buffer
  ccd_hist_mem u_hist (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wrEn    (histWrEn && !s_r.histClr),
    .wrAddr  (histWrAddr),
    .wrData  (histWrData),
    .rdAddr  (histRdAddr),
    .rdData  (histRdData),
    .clrEn   (s_r.histClr),
    .clrAddr (s_r.histPtr)
  );

  assign eng             = s_r.eng;
  assign portADataOeN    = s_r.aOeN;
  assign portBDataOeN    = s_r.bOeN;
  assign pausedInt       = s_r.pInt;
  assign pausedStat      = s_r.pStat;
  assign busyStat        = s_r.busy;
  assign portACfgEn      = s_r.aCfg;
  assign portBCfgEn      = s_r.bCfg;
  assign portAFifoCtlEn  = s_r.aFifo;
  assign softResetPulse  = s_r.swPulse;
  assign swrstInProgress = s_r.swBusy;
  assign regRdData       = s_r.rd;
  assign histClearing    = s_r.histClr;

  // ============================================================
  // assertions
  sequence s_pauseCmd;
    s_r.st == ST_BUSY && dec.pause && !dec.start && !xferDone;
  endsequence
  sequence s_pauseStep;
    s_r.st == ST_PAUSING && stepDone;
  endsequence

  a_reset_cmd_val: assert property (@(posedge clk_sys) $rose(nrst) |-> s_r.cmd == CMD_RESET_VAL)
    else $error("command register not zero after reset");
  a_swrst_readback: assert property (@(posedge clk_sys) disable iff (!nrst)
    (dec.swReset && s_r.st != ST_SWRST) |=> s_r.cmd == CMD_SWRESET && softResetPulse)
    else $error("soft reset code not held");
  a_swrst_length: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(swrstInProgress) |-> swrstInProgress [*8] ##1 swrstInProgress [*4] ##1 !swrstInProgress)
    else $error("soft reset not twelve clocks");
  a_swrst_cancel: assert property (@(posedge clk_sys) disable iff (!nrst)
    softResetPulse |-> !eng.run && !busyStat && histClearing)
    else $error("soft reset did not cancel");
  a_pause_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_pauseCmd |=> s_r.st == ST_PAUSING && !portADataOeN && !portBDataOeN)
    else $error("pause floated buses before step end");
  a_pause_float: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_pauseStep |=> portADataOeN && portBDataOeN && pausedStat)
    else $error("pause did not float buses");
  a_pause_holds: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_PAUSED && !dec.resume && !dec.swReset && !dec.start) |=> $stable(eng.mode))
    else $error("paused mode lost");
  a_paused_bits: assert property (@(posedge clk_sys) disable iff (!nrst)
    s_pauseStep |=> pausedInt && pausedStat && !eng.run)
    else $error("paused bits not set");
  a_resume_busy: assert property (@(posedge clk_sys) disable iff (!nrst)
    (s_r.st == ST_PAUSED && dec.resume && !dec.swReset) |=> busyStat && !pausedStat && !pausedInt
      && eng.padInsertA == s_r.cmd[1:0] && eng.padExpectB == s_r.cmd[3:2])
    else $error("resume wrong");
  a_sel_a_fifo: assert property (@(posedge clk_sys) disable iff (!nrst)
    portAFifoCtlEn |-> s_r.cmd == CMD_SEL_A)
    else $error("fifo control open without selection");
  a_sel_b_cfg: assert property (@(posedge clk_sys) disable iff (!nrst)
    portBCfgEn == (s_r.cmd == CMD_SEL_B))
    else $error("port b selection mismatch");
  a_comp_pads: assert property (@(posedge clk_sys) disable iff (!nrst)
    (dec.start && is_comp(dec.xfer) && !dec.swReset && s_r.st inside {ST_IDLE, ST_BUSY})
      |=> eng.startPulse && eng.padExpectA == s_r.cmd[3:2] && eng.padInsertB == s_r.cmd[1:0])
    else $error("compression pads wrong");
  a_hist_walk: assert property (@(posedge clk_sys) disable iff (!nrst)
    (dec.histReset && s_r.st != ST_SWRST) |=> histClearing [*8] ##1 histClearing [*8] ##1 !histClearing)
    else $error("history clear length wrong");
endmodule
`default_nettype wire

/* pkg/ccd_pkg.sv */
// ============================================================
// command decoder constants and types
package ccd_pkg;

  // register addresses (host bus mode select low)
  localparam logic [4:0]  CMD_ADDR_LO     = 5'h10;
  localparam logic [4:0]  CMD_ADDR_HI     = 5'h11;
  localparam logic [15:0] CMD_RESET_VAL   = 16'h0000;

  // command codes
  localparam logic [15:0] CMD_NOP         = 16'h0000;
  localparam logic [15:0] CMD_SEL_A       = 16'hc100;
  localparam logic [15:0] CMD_SEL_B       = 16'hc200;
  localparam logic [15:0] CMD_PAUSE       = 16'h4200;
  localparam logic [15:0] CMD_SWRESET     = 16'ha000;
  localparam logic [15:0] CMD_HISTRESET   = 16'ha400;
  // upper twelve bits of ranged codes
  localparam logic [11:0] CMD_CBYP_HI     = 12'h500;
  localparam logic [11:0] CMD_COMP_HI     = 12'h580;
  localparam logic [11:0] CMD_DBYP_HI     = 12'h600;
  localparam logic [11:0] CMD_DECO_HI     = 12'h680;
  localparam logic [11:0] CMD_DOFF_HI     = 12'h6c0;
  localparam logic [11:0] CMD_RESUME_HI   = 12'h440;

  // software reset takes twelve device clocks
  localparam int          SWRST_CLOCKS    = 12;
  localparam logic [3:0]  SWRST_LAST      = 4'(SWRST_CLOCKS - 1);
  // history buffer clear walks all entries
  localparam int          HIST_AW         = 4;
  localparam logic [HIST_AW-1:0] HIST_LAST = '1;

  typedef enum logic [2:0] {
    XF_NONE, XF_CBYP, XF_COMP, XF_DBYP, XF_DECO, XF_DOFF
  } ccd_xfer_t;

  typedef enum {
    ST_IDLE, ST_BUSY, ST_PAUSING, ST_PAUSED, ST_SWRST
  } ccd_state_t;

  // decoded command
  typedef struct packed {
    logic      selA;
    logic      selB;
    logic      start;
    ccd_xfer_t xfer;
    logic      pause;
    logic      resume;
    logic      swReset;
    logic      histReset;
  } ccd_dec_t;

  // controls toward the transfer engine
  typedef struct packed {
    ccd_xfer_t  mode;
    logic       run;
    logic [1:0] padExpectA;
    logic [1:0] padInsertA;
    logic [1:0] padExpectB;
    logic [1:0] padInsertB;
    logic       startPulse;
    logic       cancelPulse;
  } ccd_eng_t;

endpackage

/* core/ccd_hist_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// history buffer store with registered read and bulk clear port
module ccd_hist_mem (
  // clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // engine access
  input  wire logic                      wrEn,
  input  wire logic [ccd_pkg::HIST_AW-1:0] wrAddr,
  input  wire logic [7:0]                wrData,
  input  wire logic [ccd_pkg::HIST_AW-1:0] rdAddr,
  output logic      [7:0]                rdData,
  // clear walk
  input  wire logic                      clrEn,
  input  wire logic [ccd_pkg::HIST_AW-1:0] clrAddr
);
  import ccd_pkg::*;

  logic [7:0] mem [2**HIST_AW];

  always_ff @(posedge clk_sys) begin
    if (clrEn) begin
      mem[clrAddr] <= 8'h00;
    end else if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rdData <= 8'h00;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule
`default_nettype wire

/* tb/ccd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// host side of the byte-wide register port
module ccd_host_model (
  // clock and bus mode
  input  wire logic       clk_sys,
  input  wire logic       hostBusModeSelect,
  // register port
  output logic      [4:0] regAddr,
  output logic            regWr,
  output logic      [7:0] regWrData,
  output logic            regRd,
  input  wire logic [7:0] regRdData
);
  import ccd_pkg::*;

  initial begin
    regAddr = 5'h00;
    regWr = 1'b0;
    regWrData = 8'h00;
    regRd = 1'b0;
  end

  // byte address of one half of the command
  function automatic logic [4:0] cmd_addr(input logic hi);
    return (hi ^ hostBusModeSelect) ? CMD_ADDR_HI : CMD_ADDR_LO;
  endfunction

  // released lines show the inverse of the last value
  task automatic byte_wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge clk_sys);
    regWr = 1'b0;
    regWrData = ~d;
    regAddr = ~a;
  endtask

  task automatic byte_rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clk_sys);
    regRd = 1'b0;
    regAddr = ~a;
    d = regRdData;
  endtask

  // callers hand only defined codes; low byte first
  task automatic cmd_wr(input logic [15:0] c);
    byte_wr(cmd_addr(1'b0), c[7:0]);
    byte_wr(cmd_addr(1'b1), c[15:8]);
    if (c === CMD_SWRESET) begin
      repeat (SWRST_CLOCKS) @(posedge clk_sys);
    end
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// command decoder bench
module tb_top;
  import ccd_pkg::*;

  typedef struct packed {
    logic [15:0] code;
    ccd_xfer_t   mode;
    logic [1:0]  padE;
    logic [1:0]  padI;
  } ccd_row_t;

  logic clk_sys, nrst, hostBusModeSelect, regWr, regRd, stepDone, xferDone;
  logic pausedIntClr, pausedInt, pausedStat, busyStat, histWrEn, histClearing;
  logic portADataOeN, portBDataOeN, portACfgEn, portBCfgEn, portAFifoCtlEn;
  logic softResetPulse, swrstInProgress;
  logic [4:0] regAddr;
  logic [7:0] regWrData, regRdData, histWrData, histRdData, rd;
  logic [HIST_AW-1:0] histWrAddr, histRdAddr;
  ccd_eng_t eng;
  int fails, num_checks, nStart, nSw, nSwCyc, nClr, n0, nCan;
  ccd_row_t rows [6];

  ccd_host_model host (.clk_sys(clk_sys), .hostBusModeSelect(hostBusModeSelect), .regAddr(regAddr),
    .regWr(regWr), .regWrData(regWrData), .regRd(regRd), .regRdData(regRdData));

  ccd_decoder dut (.clk_sys(clk_sys), .nrst(nrst), .hostBusModeSelect(hostBusModeSelect),
    .regAddr(regAddr), .regWr(regWr), .regWrData(regWrData), .regRd(regRd), .regRdData(regRdData),
    .stepDone(stepDone), .xferDone(xferDone), .eng(eng), .portADataOeN(portADataOeN),
    .portBDataOeN(portBDataOeN), .pausedIntClr(pausedIntClr), .pausedInt(pausedInt),
    .pausedStat(pausedStat), .busyStat(busyStat), .portACfgEn(portACfgEn), .portBCfgEn(portBCfgEn),
    .portAFifoCtlEn(portAFifoCtlEn), .softResetPulse(softResetPulse), .swrstInProgress(swrstInProgress),
    .histWrEn(histWrEn), .histWrAddr(histWrAddr), .histWrData(histWrData), .histRdAddr(histRdAddr),
    .histRdData(histRdData), .histClearing(histClearing));

  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  // pulse and level counters
  always @(posedge clk_sys) begin
    if (eng.startPulse === 1'b1) nStart++;
    if (softResetPulse === 1'b1) nSw++;
    if (swrstInProgress === 1'b1) nSwCyc++;
    if (histClearing === 1'b1) nClr++;
    if (eng.cancelPulse === 1'b1) nCan++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic cmd_rd(input logic [15:0] exp);
    host.byte_rd(host.cmd_addr(1'b0), rd);
    chk(rd, exp[7:0]);
    host.byte_rd(host.cmd_addr(1'b1), rd);
    chk(rd, exp[15:8]);
  endtask

  task automatic give_verdict;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end

  initial begin
    {nrst, hostBusModeSelect, stepDone, xferDone, pausedIntClr, histWrEn} = 6'h00;
    {histWrAddr, histRdAddr, histWrData} = 16'h0000;
    rows = '{'{16'h500f, XF_CBYP, 2'h3, 2'h3}, '{16'h5806, XF_COMP, 2'h1, 2'h2},
             '{16'h6009, XF_DBYP, 2'h2, 2'h1}, '{16'h680c, XF_DECO, 2'h3, 2'h0},
             '{16'h6c03, XF_DOFF, 2'h0, 2'h3}, '{16'h5000, XF_CBYP, 2'h0, 2'h0}};
    settle(6);
    nrst = 1'b1;
    cmd_rd(CMD_RESET_VAL);
    chk({busyStat, portADataOeN, portBDataOeN}, 3'h3);
    // starts with pad fields
    foreach (rows[k]) begin
      n0 = nStart;
      host.cmd_wr(rows[k].code);
      settle(3);
      chk(16'(nStart - n0), 16'h1);
      chk(eng.mode, rows[k].mode);
      chk({eng.run, busyStat, portADataOeN, portBDataOeN}, 4'hc);
      if (rows[k].mode inside {XF_CBYP, XF_COMP}) begin
        chk(eng.padExpectA, rows[k].padE);
        chk(eng.padInsertB, rows[k].padI);
      end else begin
        chk(eng.padExpectB, rows[k].padE);
        chk(eng.padInsertA, rows[k].padI);
      end
      pulse(xferDone);
      settle(2);
    end
    // selections and byte order under both bus modes
    for (int m = 0; m < 2; m++) begin
      hostBusModeSelect = m[0];
      host.cmd_wr(CMD_SEL_A);
      settle(2);
      chk({portACfgEn, portAFifoCtlEn, portBCfgEn}, 3'h6);
      cmd_rd(CMD_SEL_A);
      host.cmd_wr(CMD_SEL_B);
      settle(2);
      chk({portACfgEn, portAFifoCtlEn, portBCfgEn}, 3'h1);
      host.byte_rd(5'h0a, rd);
      chk(rd, 8'h00);
    end
    hostBusModeSelect = 1'b0;
    // history clear between operations
    @(negedge clk_sys);
    {histWrEn, histWrAddr, histWrData, histRdAddr} = {1'b1, 4'h3, 8'h5a, 4'h3};
    @(negedge clk_sys);
    histWrEn = 1'b0;
    settle(2);
    chk(histRdData, 8'h5a);
    {nClr, n0} = {32'd0, nSw};
    host.cmd_wr(CMD_HISTRESET);
    settle(20);
    chk(16'(nClr), 16'd16);
    chk(16'(nSw - n0), 16'h0);
    chk(histRdData, 8'h00);
    // pause, refused start, resume, nop
    host.cmd_wr(16'h5806);
    host.cmd_wr(CMD_PAUSE);
    settle(4);
    chk({pausedStat, portADataOeN, portBDataOeN}, 3'h0);
    pulse(stepDone);
    settle(2);
    chk({portADataOeN, portBDataOeN}, 2'h3);
    chk({pausedInt, pausedStat, eng.run}, 3'h6);
    n0 = nStart;
    host.cmd_wr(16'h6000);
    settle(3);
    chk({eng.mode, eng.padExpectA, eng.padInsertB}, {XF_COMP, 2'h1, 2'h2});
    chk(16'(nStart - n0), 16'h0);
    host.cmd_wr(16'h4409);
    settle(3);
    chk({pausedInt, pausedStat, busyStat, eng.run}, 4'h3);
    chk({eng.padExpectB, eng.padInsertA, eng.mode}, {2'h2, 2'h1, XF_COMP});
    host.cmd_wr(CMD_NOP);
    settle(3);
    chk({busyStat, eng.run, eng.mode}, {2'h3, XF_COMP});
    chk(16'(nStart - n0), 16'h0);
    host.cmd_wr(CMD_PAUSE);
    pulse(stepDone);
    pulse(pausedIntClr);
    settle(2);
    chk({pausedInt, pausedStat}, 2'h1);
    // soft reset while paused
    {nSwCyc, nClr, n0} = {32'd0, 32'd0, nSw};
    host.cmd_wr(CMD_SWRESET);
    settle(8);
    chk(16'(nSw - n0), 16'h1);
    chk(16'(nCan), 16'h1);
    chk(16'(nSwCyc), 16'(SWRST_CLOCKS));
    chk(16'(nClr), 16'd16);
    chk({busyStat, pausedInt, pausedStat, eng.run, eng.mode}, {4'h0, XF_NONE});
    chk({portADataOeN, portBDataOeN}, 2'h3);
    cmd_rd(CMD_SWRESET);
    // hardware reset in mid-transfer
    host.cmd_wr(16'h6c03);
    settle(2);
    chk({busyStat, eng.run}, 2'h3);
    nrst = 1'b0;
    settle(2);
    nrst = 1'b1;
    chk({busyStat, eng.run, portADataOeN, portBDataOeN, portACfgEn}, 5'h06);
    chk(eng.mode, XF_NONE);
    cmd_rd(CMD_RESET_VAL);
    give_verdict();
  end
endmodule
`default_nettype wire
